// *** udc_pkg.sv ***
// constants, register map and mode codes of the up/down counter compare unit
//
// Behaviour
// - each timer tick clears, increments or decrements the counter per waveform mode.
// - tick source select zero stops the counter.
// - software reads and writes the counter at any time.
// - a software counter write beats any same-cycle clear or count.
// - the two waveform mode bits in the control register pick the count sequence.
// - overflow flag set as the mode defines and can raise an interrupt.
// - 8-bit comparator flags a match whenever counter equals compare value.
// - a match sets the compare flag on the following timer tick.
// - compare irq enable at one lets a set compare flag request an interrupt.
// - compare flag clears on interrupt service or on software writing one.
// - output built from match, waveform mode, compare output mode, max and bottom.
// - compare value double buffered in PWM modes, direct in normal and clear-on-match.
// - buffered compare value moves to the active one only on a tick at max.
// - software compare accesses reach the buffer when buffered, else the active value.
// - force strobe in non-PWM modes acts on the output like a real match.
// - forced compare sets no flag, leaves counter alone, obeys compare output mode.
// - a counter write blocks the compare flag and output change of a match on the next tick, even stopped.
// - the compare output state survives a waveform mode change.
// - compare output mode bits are not buffered and act at once.
// - bottom is 0x00, max 0xFF, top is max or the compare value.
// - tick from core clock by default, from the oscillator when async selected.

package udc_pkg;

  localparam int unsigned CNT_W = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PRE_W = 10;

  // register offsets
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_COUNT = 3'h1;
  localparam logic [2:0] ADDR_COMPARE = 3'h2;
  localparam logic [2:0] ADDR_FLAGS = 3'h3;
  localparam logic [2:0] ADDR_IRQ_EN = 3'h4;
  localparam logic [2:0] ADDR_ASYNC = 3'h5;

  // timer_control_reg fields
  localparam int unsigned CTRL_CS_LSB = 0;
  localparam int unsigned CTRL_CS_W = 3;
  localparam int unsigned CTRL_COM_LSB = 3;
  localparam int unsigned CTRL_WGM_LSB = 5;
  localparam int unsigned CTRL_FORCE_BIT = 7;

  // flag and enable bit positions
  localparam int unsigned FLAG_OVF_BIT = 0;
  localparam int unsigned FLAG_CMP_BIT = 1;
  localparam int unsigned ASYNC_SEL_BIT = 0;

  // counter extremes
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    WGM_NORMAL = 2'h0,
    WGM_PHASE = 2'h1,
    WGM_CTC = 2'h2,
    WGM_FAST = 2'h3
  } udc_wgm_e;

  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // tick source select codes and prescaler masks
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [9:0] PRE_MASK_1 = 10'h000;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_32 = 10'h01f;
  localparam logic [9:0] PRE_MASK_64 = 10'h03f;
  localparam logic [9:0] PRE_MASK_128 = 10'h07f;
  localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

endpackage

// *** udc_timer.sv ***
// up/down counter with compare channel, register port and prescaler
`timescale 1ns/1ps
`default_nettype none

module udc_timer (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // timer oscillator tick, one-cycle pulse
  input wire logic osc_tick_i,
  // interrupt service acknowledges
  input wire logic ovf_irq_ack_i,
  input wire logic cmp_irq_ack_i,
  // interrupt requests and compare output
  output logic ovf_irq_o,
  output logic cmp_irq_o,
  output logic compare_output_o
);

  // shared by forced and real non-PWM matches
  function automatic logic udc_oc_act(input logic [1:0] com, input logic oc);
    case (com)
      udc_pkg::COM_TOGGLE: udc_oc_act = ~oc;
      udc_pkg::COM_CLEAR: udc_oc_act = 1'b0;
      udc_pkg::COM_SET: udc_oc_act = 1'b1;
      default: udc_oc_act = oc;
    endcase
  endfunction

  function automatic logic [9:0] udc_pre_mask(input logic [2:0] cs);
    case (cs)
      3'h1: udc_pre_mask = udc_pkg::PRE_MASK_1;
      3'h2: udc_pre_mask = udc_pkg::PRE_MASK_8;
      3'h3: udc_pre_mask = udc_pkg::PRE_MASK_32;
      3'h4: udc_pre_mask = udc_pkg::PRE_MASK_64;
      3'h5: udc_pre_mask = udc_pkg::PRE_MASK_128;
      3'h6: udc_pre_mask = udc_pkg::PRE_MASK_256;
      3'h7: udc_pre_mask = udc_pkg::PRE_MASK_1024;
      default: udc_pre_mask = udc_pkg::PRE_MASK_1;
    endcase
  endfunction

  // state
  logic [2:0] cs_q;
  logic [1:0] com_q;
  udc_pkg::udc_wgm_e wgm_q;
  logic async_q;
  logic [9:0] pre_q;
  logic [7:0] cnt_q, cnt_d;
  logic up_q, up_d;
  logic [7:0] ocr_q, ocr_d;
  logic [7:0] ocr_buf_q, ocr_buf_d;
  logic block_q, block_d;
  logic ovf_flag_q, ovf_flag_d;
  logic cmp_flag_q, cmp_flag_d;
  logic ovf_ie_q;
  logic cie_q;
  logic oc_q, oc_d;
  logic ovf_irq_q, cmp_irq_q;
  logic [7:0] rdata_q, rdata_d;

  // register decode
  logic ctrl_we_w, cnt_we_w, cmp_we_w, flags_we_w, ien_we_w, async_we_w;
  assign ctrl_we_w = reg_we_i & (reg_addr_i == udc_pkg::ADDR_CTRL);
  assign cnt_we_w = reg_we_i & (reg_addr_i == udc_pkg::ADDR_COUNT);
  assign cmp_we_w = reg_we_i & (reg_addr_i == udc_pkg::ADDR_COMPARE);
  assign flags_we_w = reg_we_i & (reg_addr_i == udc_pkg::ADDR_FLAGS);
  assign ien_we_w = reg_we_i & (reg_addr_i == udc_pkg::ADDR_IRQ_EN);
  assign async_we_w = reg_we_i & (reg_addr_i == udc_pkg::ADDR_ASYNC);

  logic [1:0] wr_com_w, wr_wgm_w;
  logic wr_force_w;
  assign wr_com_w = reg_wdata_i[udc_pkg::CTRL_COM_LSB +: 2];
  assign wr_wgm_w = reg_wdata_i[udc_pkg::CTRL_WGM_LSB +: 2];
  assign wr_force_w = reg_wdata_i[udc_pkg::CTRL_FORCE_BIT];

  // tick generation
  logic src_en_w, tick_w;
  logic [9:0] mask_w;
  assign src_en_w = async_q ? osc_tick_i : 1'b1;
  assign mask_w = udc_pre_mask(cs_q);
  assign tick_w = src_en_w & (cs_q != udc_pkg::CS_STOP)
                & ((pre_q & mask_w) == mask_w);

  // mode decode
  logic pwm_w, phase_w, ctc_w, fast_w;
  assign pwm_w = wgm_q[0];
  assign phase_w = (wgm_q == udc_pkg::WGM_PHASE);
  assign ctc_w = (wgm_q == udc_pkg::WGM_CTC);
  assign fast_w = (wgm_q == udc_pkg::WGM_FAST);

  // counter unit
  logic at_max_w, at_bottom_w, match_w, up_next_w;
  logic [7:0] cnt_step_w, cnt_tick_w;
  assign at_max_w = (cnt_q == udc_pkg::CNT_MAX);
  assign at_bottom_w = (cnt_q == udc_pkg::CNT_BOTTOM);
  assign match_w = (cnt_q == ocr_q);
  assign up_next_w = !phase_w ? 1'b1 :
                     at_max_w ? 1'b0 :
                     at_bottom_w ? 1'b1 : up_q;
  assign cnt_step_w = up_next_w ? cnt_q + 8'h01 : cnt_q - 8'h01;
  assign cnt_tick_w = (ctc_w & match_w) ? udc_pkg::CNT_BOTTOM
                                        : cnt_step_w;
  // software write beats the tick
  assign cnt_d = cnt_we_w ? reg_wdata_i :
                 tick_w ? cnt_tick_w : cnt_q;
  assign up_d = tick_w ? up_next_w : up_q;

  // overflow: max in single-slope modes, bottom on the way down otherwise
  logic ovf_set_w;
  assign ovf_set_w = tick_w & (phase_w ? (at_bottom_w & ~up_q)
                                       : at_max_w);
  assign ovf_flag_d = ovf_set_w | (ovf_flag_q & ~ovf_irq_ack_i
                    & ~(flags_we_w & reg_wdata_i[udc_pkg::FLAG_OVF_BIT]));

  // compare match blocking after a counter write
  logic hit_w;
  assign hit_w = tick_w & match_w & ~block_q;
  assign block_d = cnt_we_w ? 1'b1 : tick_w ? 1'b0 : block_q;

  // set wins over a same-cycle clear
  assign cmp_flag_d = hit_w | (cmp_flag_q & ~cmp_irq_ack_i
                    & ~(flags_we_w & reg_wdata_i[udc_pkg::FLAG_CMP_BIT]));

  // double buffered compare value
  logic ocr_load_w;
  assign ocr_load_w = pwm_w & tick_w & at_max_w;
  assign ocr_buf_d = cmp_we_w ? reg_wdata_i : ocr_buf_q;
  assign ocr_d = (cmp_we_w & ~pwm_w) ? reg_wdata_i :
                 ocr_load_w ? ocr_buf_q : ocr_q;

  // waveform generator; com_q is used unbuffered
  logic force_w, fast_bottom_w, oc_pwm_w, oc_bottom_w, oc_hit_w;
  assign force_w = ctrl_we_w & wr_force_w & ~wr_wgm_w[0];
  assign fast_bottom_w = tick_w & fast_w & at_max_w;
  assign oc_pwm_w = com_q[1] ? ((com_q == udc_pkg::COM_SET)
                               ^ (phase_w & ~up_q)) : oc_q;
  assign oc_bottom_w = com_q[1] ? ~com_q[0] : oc_q;
  assign oc_hit_w = pwm_w ? oc_pwm_w : udc_oc_act(com_q, oc_q);
  assign oc_d = force_w ? udc_oc_act(wr_com_w, oc_q) :
                fast_bottom_w ? oc_bottom_w :
                hit_w ? oc_hit_w : oc_q;

  // read mux
  logic [7:0] rd_mux_w;
  assign rd_mux_w =
    (reg_addr_i == udc_pkg::ADDR_CTRL) ?
      {1'b0, wgm_q, com_q, cs_q} :
    (reg_addr_i == udc_pkg::ADDR_COUNT) ? cnt_q :
    (reg_addr_i == udc_pkg::ADDR_COMPARE) ?
      (pwm_w ? ocr_buf_q : ocr_q) :
    (reg_addr_i == udc_pkg::ADDR_FLAGS) ?
      {6'h00, cmp_flag_q, ovf_flag_q} :
    (reg_addr_i == udc_pkg::ADDR_IRQ_EN) ?
      {6'h00, cie_q, ovf_ie_q} :
    (reg_addr_i == udc_pkg::ADDR_ASYNC) ?
      {7'h00, async_q} : udc_pkg::BYTE_RST;
  assign rdata_d = reg_re_i ? rd_mux_w : udc_pkg::BYTE_RST;

  // control registers; the force bit is never stored
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cs_q <= udc_pkg::CS_STOP;
      com_q <= udc_pkg::COM_OFF;
      wgm_q <= udc_pkg::WGM_NORMAL;
    end else if (ctrl_we_w) begin
      cs_q <= reg_wdata_i[udc_pkg::CTRL_CS_LSB +: udc_pkg::CTRL_CS_W];
      com_q <= wr_com_w;
      wgm_q <= udc_pkg::udc_wgm_e'(wr_wgm_w);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ovf_ie_q <= 1'b0;
      cie_q <= 1'b0;
      async_q <= 1'b0;
    end else begin
      if (ien_we_w) begin
        ovf_ie_q <= reg_wdata_i[udc_pkg::FLAG_OVF_BIT];
        cie_q <= reg_wdata_i[udc_pkg::FLAG_CMP_BIT];
      end
      if (async_we_w) begin
        async_q <= reg_wdata_i[udc_pkg::ASYNC_SEL_BIT];
      end
    end
  end

  // prescaler free-runs on the selected source
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pre_q <= 10'h000;
    end else if (src_en_w) begin
      pre_q <= pre_q + 10'h001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_q <= udc_pkg::CNT_BOTTOM;
      up_q <= 1'b1;
      block_q <= 1'b0;
      ocr_q <= udc_pkg::BYTE_RST;
      ocr_buf_q <= udc_pkg::BYTE_RST;
    end else begin
      cnt_q <= cnt_d;
      up_q <= up_d;
      block_q <= block_d;
      ocr_q <= ocr_d;
      ocr_buf_q <= ocr_buf_d;
    end
  end

  // request lags the flag by one cycle so outputs stay flop-driven
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ovf_flag_q <= 1'b0;
      cmp_flag_q <= 1'b0;
      oc_q <= 1'b0;
      ovf_irq_q <= 1'b0;
      cmp_irq_q <= 1'b0;
      rdata_q <= udc_pkg::BYTE_RST;
    end else begin
      ovf_flag_q <= ovf_flag_d;
      cmp_flag_q <= cmp_flag_d;
      oc_q <= oc_d;
      ovf_irq_q <= ovf_flag_q & ovf_ie_q;
      cmp_irq_q <= cmp_flag_q & cie_q;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign ovf_irq_o = ovf_irq_q;
  assign cmp_irq_o = cmp_irq_q;
  assign compare_output_o = oc_q;

  // checks
  stop_hold_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    (cs_q == udc_pkg::CS_STOP) && !cnt_we_w |=> cnt_q == $past(cnt_q))
    else $error("counter moved while stopped");

  write_prio_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    cnt_we_w |=> cnt_q == $past(reg_wdata_i))
    else $error("counter write lost");

  match_flag_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    tick_w && match_w && !block_q |=> cmp_flag_q)
    else $error("match did not set compare flag");

  write_block_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    cnt_we_w ##1 (!tick_w && !cnt_we_w)[*2] ##1 tick_w && !cmp_flag_q
    |=> !cmp_flag_q)
    else $error("blocked match set the flag");

  cmp_irq_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    cmp_flag_q && cie_q |=> cmp_irq_o)
    else $error("compare irq not raised");

  ack_clear_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    cmp_irq_ack_i && !hit_w |=> !cmp_flag_q ##1 !cmp_irq_o)
    else $error("service did not clear compare flag");

  buf_hold_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    pwm_w && !(tick_w && at_max_w) && !ctrl_we_w |=> $stable(ocr_q))
    else $error("active compare moved off top");

  force_set_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    force_w && wr_com_w == udc_pkg::COM_SET |=> compare_output_o)
    else $error("forced set not applied");

  force_noflag_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    force_w && !hit_w && !cmp_flag_q |=> !cmp_flag_q && $stable(cnt_q)
      || $past(tick_w) || $past(cnt_we_w))
    else $error("forced compare touched flag or counter");

  normal_wrap_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    tick_w && wgm_q == udc_pkg::WGM_NORMAL && at_max_w && !cnt_we_w
    |=> cnt_q == udc_pkg::CNT_BOTTOM && ovf_flag_q)
    else $error("normal mode wrap wrong");

  mode_keep_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    ctrl_we_w && !wr_force_w && !tick_w |=> $stable(compare_output_o))
    else $error("mode change moved compare output");

  tick_stop_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    cs_q == udc_pkg::CS_STOP |-> !tick_w)
    else $error("tick while stopped");

  read_count_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    reg_re_i && reg_addr_i == udc_pkg::ADDR_COUNT
    |=> reg_rdata_o == $past(cnt_q))
    else $error("counter read wrong");

  count_up_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    tick_w && !cnt_we_w && wgm_q == udc_pkg::WGM_NORMAL
    |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("normal mode did not count up");

  ctc_clear_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    tick_w && ctc_w && match_w && !cnt_we_w |=> cnt_q == udc_pkg::CNT_BOTTOM)
    else $error("clear on match missed");

  phase_down_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    tick_w && phase_w && !up_next_w && !cnt_we_w
    |=> cnt_q == $past(cnt_q) - 8'h01)
    else $error("phase mode did not count down");

  phase_ovf_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    tick_w && phase_w && at_bottom_w && !up_q |=> ovf_flag_q)
    else $error("phase mode overflow missed");

  ovf_irq_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    ovf_flag_q && ovf_ie_q |=> ovf_irq_o)
    else $error("overflow irq not raised");

  tick_only_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    !tick_w && !cmp_flag_q |=> !cmp_flag_q)
    else $error("compare flag set without tick");

  sw_clear_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    flags_we_w && reg_wdata_i[udc_pkg::FLAG_CMP_BIT] && !hit_w
    |=> !cmp_flag_q)
    else $error("write one did not clear flag");

  buf_write_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    cmp_we_w && pwm_w && !ocr_load_w
    |=> ocr_buf_q == $past(reg_wdata_i) && $stable(ocr_q))
    else $error("buffered compare write wrong");

  direct_write_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    cmp_we_w && !pwm_w |=> ocr_q == $past(reg_wdata_i))
    else $error("direct compare write wrong");

  buf_load_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    ocr_load_w |=> ocr_q == $past(ocr_buf_q))
    else $error("buffer not moved at top");

  force_clear_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    force_w && wr_com_w == udc_pkg::COM_CLEAR |=> !compare_output_o)
    else $error("forced clear not applied");

  force_read_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    reg_re_i && reg_addr_i == udc_pkg::ADDR_CTRL
    |=> !reg_rdata_o[udc_pkg::CTRL_FORCE_BIT])
    else $error("force strobe read back set");

  com_now_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    ctrl_we_w |=> com_q == $past(wr_com_w))
    else $error("compare output mode delayed");

  fast_bottom_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    fast_bottom_w && com_q == udc_pkg::COM_CLEAR && !force_w
    |=> compare_output_o)
    else $error("fast mode wrap did not set output");

endmodule

`default_nettype wire

// *** udc_timer_tb.sv ***
// self-checking testbench of the up/down counter compare unit
`timescale 1ns/1ps
`default_nettype none

module udc_timer_tb;
  localparam logic [2:0] CTL = udc_pkg::ADDR_CTRL;
  localparam logic [2:0] CNT = udc_pkg::ADDR_COUNT;
  localparam logic [2:0] CMP = udc_pkg::ADDR_COMPARE;
  localparam logic [2:0] FLG = udc_pkg::ADDR_FLAGS;
  localparam logic [2:0] IEN = udc_pkg::ADDR_IRQ_EN;
  localparam logic [2:0] ASY = udc_pkg::ADDR_ASYNC;

  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic osc_tick_i = 1'b0;
  logic ovf_irq_ack_i = 1'b0;
  logic cmp_irq_ack_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic ovf_irq_o;
  logic cmp_irq_o;
  logic compare_output_o;
  wire logic [2:0] outs = {ovf_irq_o, cmp_irq_o, compare_output_o};
  logic re_q = 1'b0;
  logic [7:0] exp_q[$];
  int errors = 0;
  int check_count = 0;
  logic [7:0] rv;
  logic [1:0] com_tab [5] = '{2'h2, 2'h3, 2'h1, 2'h1, 2'h0};
  logic out_tab [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  always #2 core_clk_i = ~core_clk_i;

  udc_timer uut (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o),
    .osc_tick_i(osc_tick_i),
    .ovf_irq_ack_i(ovf_irq_ack_i),
    .cmp_irq_ack_i(cmp_irq_ack_i),
    .ovf_irq_o(ovf_irq_o),
    .cmp_irq_o(cmp_irq_o),
    .compare_output_o(compare_output_o)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one idle cycle after each access keeps every strobe a single pulse
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_we_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(e);
    @(posedge core_clk_i);
    reg_re_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // outputs are registered levels, so look at them mid-cycle
  task automatic lv(input logic [2:0] e);
    @(negedge core_clk_i);
    check({5'h00, outs}, {5'h00, e});
    @(posedge core_clk_i);
  endtask

  // n ticks at cs=1: the stop write edge still ticks, so n must be >= 2
  task automatic run(input logic [1:0] m, input logic [1:0] c, input int n);
    wr(CTL, {1'b0, m, c, 3'h1});
    repeat (n - 2) @(posedge core_clk_i);
    wr(CTL, {1'b0, m, c, 3'h0});
  endtask

  always @(posedge core_clk_i) re_q <= reg_re_i;

  always @(negedge core_clk_i) begin
    if (re_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("wrong value at %0t: read data with no note", $time);
      end else begin
        check(reg_rdata_o, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h6a9c));
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], 8'h00);
    end
    wr(3'h6, 8'h5a);
    rd(3'h6, 8'h00);
    lv(3'h0);
    for (int i = 0; i < 4; i++) begin
      rv = 8'($urandom % 255);
      wr(CNT, rv);
      repeat (3) @(posedge core_clk_i);
      rd(CNT, rv);
    end
    wr(CTL, 8'h01);
    wr(CNT, 8'h80);
    wr(CTL, 8'h00);
    rd(CNT, 8'h82);
    wr(CNT, 8'hfe);
    run(2'h0, 2'h0, 3);
    rd(CNT, 8'h01);
    rd(FLG, 8'h03);
    wr(IEN, 8'h01);
    lv(3'h4);
    ovf_irq_ack_i <= 1'b1;
    cmp_irq_ack_i <= 1'b1;
    @(posedge core_clk_i);
    ovf_irq_ack_i <= 1'b0;
    cmp_irq_ack_i <= 1'b0;
    @(posedge core_clk_i);
    lv(3'h0);
    rd(FLG, 8'h00);
    wr(IEN, 8'h00);
    // count equal to compare while stopped: first tick must not match
    wr(CMP, 8'h10);
    wr(CNT, 8'h10);
    run(2'h0, 2'h1, 2);
    rd(FLG, 8'h00);
    lv(3'h0);
    wr(CNT, 8'h0e);
    run(2'h0, 2'h1, 3);
    rd(CNT, 8'h11);
    rd(FLG, 8'h02);
    lv(3'h1);
    wr(IEN, 8'h02);
    lv(3'h3);
    wr(FLG, 8'h02);
    rd(FLG, 8'h00);
    lv(3'h1);
    wr(IEN, 8'h00);
    wr(ASY, 8'h01);
    rd(ASY, 8'h01);
    wr(CNT, 8'h20);
    wr(CTL, 8'h01);
    repeat (3) begin
      osc_tick_i <= 1'b1;
      @(posedge core_clk_i);
      osc_tick_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
    end
    wr(CTL, 8'h00);
    rd(CNT, 8'h23);
    wr(ASY, 8'h00);
    wr(CTL, 8'h40);
    wr(CMP, 8'h05);
    rd(CMP, 8'h05);
    wr(CNT, 8'h03);
    run(2'h2, 2'h0, 4);
    rd(CNT, 8'h01);
    rd(FLG, 8'h02);
    wr(FLG, 8'h03);
    for (int i = 0; i < 5; i++) begin
      wr(CTL, {1'b1, 2'h0, com_tab[i], 3'h0});
      lv({2'b00, out_tab[i]});
    end
    rd(CTL, 8'h00);
    rd(FLG, 8'h00);
    rd(CNT, 8'h01);
    wr(CTL, {1'b1, 2'h2, 2'h1, 3'h0});
    lv(3'h0);
    wr(CTL, {1'b1, 2'h3, 2'h1, 3'h0});
    lv(3'h0);
    rd(CTL, 8'h68);
    wr(CMP, 8'h40);
    rd(CMP, 8'h40);
    wr(CNT, 8'h03);
    run(2'h3, 2'h0, 3);
    rd(FLG, 8'h02);
    wr(FLG, 8'h03);
    wr(CNT, 8'hfe);
    run(2'h3, 2'h0, 3);
    rd(FLG, 8'h01);
    wr(FLG, 8'h03);
    wr(CNT, 8'h3e);
    run(2'h3, 2'h0, 3);
    rd(FLG, 8'h02);
    wr(FLG, 8'h03);
    wr(CNT, 8'hfe);
    run(2'h3, 2'h2, 3);
    lv(3'h1);
    wr(FLG, 8'h03);
    wr(CNT, 8'h3e);
    run(2'h3, 2'h2, 3);
    lv(3'h0);
    wr(FLG, 8'h03);
    wr(CNT, 8'hfe);
    run(2'h1, 2'h0, 4);
    rd(CNT, 8'hfc);
    wr(CNT, 8'h02);
    run(2'h1, 2'h0, 3);
    rd(CNT, 8'h01);
    rd(FLG, 8'h01);
    if (exp_q.size() != 0) begin
      errors++;
    end
    end_sim();
  end
endmodule

`default_nettype wire
